// file: logic/ssic_top.v
`include "ssic_defines.vh"
module ssic_top (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // host controls
   input wire supply_enable_in,
   input wire voltage_select_in,
   input wire card_removal_disable_n,
   // host signals
   input wire host_card_reset_in,
   input wire host_clock_in,
   input wire host_data_i,
   output reg host_data_o,
   output reg host_data_oe,
   // card signals
   output reg card_reset_out,
   output reg card_clock_out,
   input wire card_data_i,
   output reg card_data_o,
   output reg card_data_oe,
   // card supply
   output reg card_supply_out,
   output reg card_supply_oe,
   output reg supply_3v_q,
   output reg pump_on_q,
   output reg pump_clk_q,
   output reg ref_on_q,
   output reg normal_q
);
   // reset release through two stages
   reg rst_s1_q;
   reg rst_n_q;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // pin inputs, two sync stages each
   reg en_m_q;
   reg sel_m_q;
   reg rem_n_m_q;
   reg hrst_m_q;
   reg hclk_m_q;
   reg hdat_m_q;
   reg cdat_m_q;
   reg en_s_q;
   reg sel_s_q;
   reg rem_n_s_q;
   reg hrst_s_q;
   reg hclk_s_q;
   reg hdat_s_q;
   reg cdat_s_q;

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         en_m_q <= 1'b0;
         sel_m_q <= 1'b0;
         rem_n_m_q <= 1'b0;
         hrst_m_q <= 1'b0;
         hclk_m_q <= 1'b0;
         hdat_m_q <= 1'b0;
         cdat_m_q <= 1'b0;
      end else begin
         en_m_q <= supply_enable_in;
         sel_m_q <= voltage_select_in;
         rem_n_m_q <= card_removal_disable_n;
         hrst_m_q <= host_card_reset_in;
         hclk_m_q <= host_clock_in;
         hdat_m_q <= host_data_i;
         cdat_m_q <= card_data_i;
      end
   end

   // only the second stage feeds logic
   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         en_s_q <= 1'b0;
         sel_s_q <= 1'b0;
         rem_n_s_q <= 1'b0;
         hrst_s_q <= 1'b0;
         hclk_s_q <= 1'b0;
         hdat_s_q <= 1'b0;
         cdat_s_q <= 1'b0;
      end else begin
         en_s_q <= en_m_q;
         sel_s_q <= sel_m_q;
         rem_n_s_q <= rem_n_m_q;
         hrst_s_q <= hrst_m_q;
         hclk_s_q <= hclk_m_q;
         hdat_s_q <= hdat_m_q;
         cdat_s_q <= cdat_m_q;
      end
   end

   // captured supply setting
   reg sel_q;
   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sel_q <= `SSIC_SEL_5V;
      end else if (!en_s_q) begin
         sel_q <= sel_s_q;
      end
   end

   // operating mode, decoded from the synced controls
   localparam ST_DOWN = 4'b0001;
   localparam ST_GONE = 4'b0010;
   localparam ST_RUN5 = 4'b0100;
   localparam ST_RUN3 = 4'b1000;
   reg [3:0] mode_d;
   always @* begin
      case ({rem_n_s_q, en_s_q})
         2'b11: begin
            if (sel_q == `SSIC_SEL_3V) begin
               mode_d = ST_RUN3;
            end else begin
               mode_d = ST_RUN5;
            end
         end
         2'b10: begin
            mode_d = ST_DOWN;
         end
         default: begin
            mode_d = ST_GONE;
         end
      endcase
   end

   wire active = mode_d[2] | mode_d[3];
   wire pump_run = (mode_d == ST_RUN5);

   wire osc;
   ssic_pump_osc #(
      .HALF(`SSIC_OSC_HALF)
   ) u_osc (
      .clk_sys(clk_sys),
      .rst_n(rst_n_q),
      .run(pump_run),
      .osc_q(osc)
   );

   // which side pulls data low; the other side follows
   reg host_pull_q;
   reg card_pull_q;
   // own release still in the sync stages; that low is no pull
   reg [2:0] host_hold_q;
   reg [2:0] card_hold_q;
   wire host_free = (host_hold_q == 3'h0);
   wire card_free = (card_hold_q == 3'h0);
   wire host_pull_d = active & ~hdat_s_q & ~card_pull_q & host_free;
   wire card_pull_d = active & ~cdat_s_q & ~host_pull_q & card_free;
   wire card_oe_d = ~active | host_pull_d;
   wire host_oe_d = card_pull_d;

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         host_pull_q <= 1'b0;
      end else begin
         host_pull_q <= host_pull_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_pull_q <= 1'b0;
      end else begin
         card_pull_q <= card_pull_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         host_hold_q <= 3'h0;
      end else if (host_data_oe & ~host_oe_d) begin
         host_hold_q <= `SSIC_ECHO_HOLD;
      end else if (!host_free) begin
         host_hold_q <= host_hold_q - 3'h1;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_hold_q <= 3'h0;
      end else if (card_data_oe & ~card_oe_d) begin
         card_hold_q <= `SSIC_ECHO_HOLD;
      end else if (!card_free) begin
         card_hold_q <= card_hold_q - 3'h1;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_reset_out <= 1'b0;
      end else begin
         card_reset_out <= active & hrst_s_q;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_clock_out <= 1'b0;
      end else begin
         card_clock_out <= active & hclk_s_q;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_data_o <= 1'b0;
      end else begin
         card_data_o <= 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_data_oe <= 1'b0;
      end else begin
         card_data_oe <= card_oe_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         host_data_o <= 1'b0;
      end else begin
         host_data_o <= 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         host_data_oe <= 1'b0;
      end else begin
         host_data_oe <= host_oe_d;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_supply_oe <= 1'b0;
      end else begin
         card_supply_oe <= active;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         card_supply_out <= 1'b0;
      end else begin
         card_supply_out <= active;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         supply_3v_q <= 1'b0;
      end else begin
         supply_3v_q <= (mode_d == ST_RUN3);
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pump_on_q <= 1'b0;
      end else begin
         pump_on_q <= pump_run;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ref_on_q <= 1'b0;
      end else begin
         ref_on_q <= pump_run;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pump_clk_q <= 1'b0;
      end else begin
         pump_clk_q <= osc;
      end
   end

   always @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         normal_q <= 1'b0;
      end else begin
         normal_q <= active;
      end
   end
endmodule

// file: logic/ssic_defines.vh
// Operation
// - while supply enable is low the supply generator is off and the card supply is left open, whatever the voltage select.
// - while supply enable is high the card supply carries 5 V when the setting is 0 and the device's own supply when it is 1.
// - after power-up the setting is 5 V, voltage select 0.
// - the voltage select is taken only while supply enable is low and held while it stays high.
// - in the 5 V setting the charge pump runs from an internal oscillator of nominal 800 kHz.
// - in the 3 V setting pump, oscillator and reference are off and the own supply is switched to the card supply.
// - while supply enable is low the device is powered down, card reset, clock and data are low and the supply is open.
// - a low removal input forces card data, clock and reset low and opens the supply until the input is high again.
// - a low removal input overrides supply enable and voltage select.
// - removal input high and supply enable high give normal operation at the voltage captured while powered down.
// - in normal operation host reset and clock are forwarded one way to the card.
// - in normal operation data passes both ways between host data and card data.
// - both data lines have pull-ups and read high when nobody drives them low.
// - in the 3 V setting signals pass through without level translation.
`ifndef SSIC_DEFINES_VH
`define SSIC_DEFINES_VH
`define SSIC_SEL_5V 1'b0
`define SSIC_SEL_3V 1'b1
`define SSIC_CLK_HZ 25000000
`define SSIC_OSC_HZ 800000
// half period of the pump oscillator in clk_sys cycles, rounded down
`define SSIC_OSC_HALF ((`SSIC_CLK_HZ / `SSIC_OSC_HZ) / 2)
// cycles that a released data line's own low still sits in the sync stages
`define SSIC_ECHO_HOLD 3'h3
`endif

// file: logic/ssic_pump_osc.v
`include "ssic_defines.vh"
module ssic_pump_osc #(
   parameter HALF = `SSIC_OSC_HALF
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // control
   input wire run,
   // oscillator output
   output reg osc_q
);
   reg [7:0] cnt_q;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         osc_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= 8'h00;
         osc_q <= 1'b0;
      end else if (cnt_q == HALF[7:0] - 8'h01) begin
         cnt_q <= 8'h00;
         osc_q <= ~osc_q;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// file: testbench/ssic_top_properties.sv
module ssic_props (
   input logic clk_sys, nrst, supply_enable_in, card_removal_disable_n,
   input logic host_card_reset_in, host_clock_in, host_data_i, host_data_oe,
   input logic card_reset_out, card_clock_out, card_data_i, card_data_oe,
   input logic card_supply_oe, card_supply_out, supply_3v_q, pump_on_q, ref_on_q, normal_q
);
   timeunit 1ns;
   timeprecision 1ns;
   // outputs settle a few cycles after reset release
   logic [3:0] warm_q;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         warm_q <= 4'h0;
      end else if (warm_q != 4'h8) begin
         warm_q <= warm_q + 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst || warm_q != 4'h8);
   sequence on_s;
      (supply_enable_in && card_removal_disable_n)[*7];
   endsequence
   a_removal_forces_off: assert property (
      !card_removal_disable_n[*7] |-> !card_supply_oe && !card_reset_out && !card_clock_out
      && card_data_oe) else $error("removal not forcing off");
   a_powerdown_off: assert property (
      !supply_enable_in[*7] |-> !card_supply_oe && !card_reset_out && !card_clock_out
      && card_data_oe) else $error("power down not off");
   a_normal_on: assert property (
      on_s |-> normal_q && card_supply_oe && card_supply_out) else $error("not normal");
   a_reset_fwd: assert property (
      on_s |-> card_reset_out == $past(host_card_reset_in, 3)) else $error("reset path");
   a_clock_fwd: assert property (
      on_s |-> card_clock_out == $past(host_clock_in, 3)) else $error("clock path");
   a_select_held: assert property (
      on_s |-> $stable(supply_3v_q)) else $error("select moved");
   a_pump_vs_pass: assert property (
      on_s |-> pump_on_q == !supply_3v_q && ref_on_q == pump_on_q) else $error("pump state");
   a_card_to_host: assert property (
      on_s ##0 (!card_data_i && !card_data_oe)[*4] |-> !host_data_i) else $error("data up");
endmodule
bind ssic_top ssic_props u_props (.*);

// file: testbench/ssic_card_model.sv
module ssic_card_model (
   input logic card_data_oe,
   input logic pull_low,
   output logic card_data_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // open drain card line, high when released
   assign card_data_i = !(card_data_oe || pull_low);
endmodule

// file: testbench/tb_top.sv
`include "ssic_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, nrst = 0, en = 0, sel = 0, rem = 1, hr = 0, hc = 0, hp = 0, cp = 0;
   logic h_oe, c_oe, c_in, cr, cc, so, v3, pump, nq, hdo, cdo, pclk;
   int mismatches = 0, n_checks = 0;
   initial forever #20 clk_sys = ~clk_sys;
   ssic_top DUT (.clk_sys, .nrst, .supply_enable_in(en), .voltage_select_in(sel),
      .card_removal_disable_n(rem), .host_card_reset_in(hr), .host_clock_in(hc),
      .host_data_i(!(h_oe || hp)), .host_data_o(hdo), .host_data_oe(h_oe), .card_reset_out(cr),
      .card_clock_out(cc), .card_data_i(c_in), .card_data_o(cdo), .card_data_oe(c_oe),
      .card_supply_out(), .card_supply_oe(so), .supply_3v_q(v3), .pump_on_q(pump),
      .pump_clk_q(pclk), .ref_on_q(), .normal_q(nq));
   ssic_card_model card (.card_data_oe(c_oe), .pull_low(cp), .card_data_i(c_in));
   task automatic chk(input logic s, input logic e, input string m);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic t_osc;
      int n;
      logic p;
      n = 0;
      p = pclk;
      while (pclk === p && n < 100) begin
         go(1);
         n++;
      end
      n = 0;
      p = pclk;
      while (pclk === p && n < 100) begin
         go(1);
         n++;
      end
      chk(n == `SSIC_OSC_HALF, 1, "pump clock");
   endtask
   task automatic t_on(input logic s);
      sel <= s;
      go(2);
      en <= 1;
      go(6);
      chk(nq, 1, "normal");
      chk(v3, s, "select");
      chk(pump, !s, "pump");
      if (!s) t_osc;
      else chk(pclk, 0, "pump idle");
      sel <= !s;
      go(6);
      chk(v3, s, "held");
      $display("t_on done");
   endtask
   task automatic t_off;
      hr <= 0;
      hc <= 0;
      hp <= 1;
      go(1);
      en <= 0;
      go(8);
      chk(so, 0, "open");
      chk(c_oe, 1, "data low");
      hp <= 0;
      $display("t_off done");
   endtask
   task automatic t_fwd;
      hr <= 1;
      hc <= 1;
      hp <= 1;
      go(6);
      chk(cr, 1, "reset");
      chk(cc, 1, "clock");
      chk(c_in, 0, "to card");
      chk(cdo, 0, "card low only");
      chk(hdo, 0, "host low only");
      hp <= 0;
      go(6);
      cp <= 1;
      go(6);
      chk(h_oe, 1, "to host");
      cp <= 0;
      go(6);
      chk(h_oe, 0, "release");
      $display("t_fwd done");
   endtask
   task automatic t_rem;
      rem <= 0;
      go(8);
      chk(so, 0, "removed");
      chk(cr, 0, "forced");
      rem <= 1;
      go(6);
      chk(so, 1, "back");
      $display("t_rem done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      go(8);
      nrst <= 1;
      go(6);
      t_on(0);
      t_fwd;
      t_rem;
      t_off;
      t_on(1);
      t_off;
      wrap_up;
   end
endmodule
